// ---- rtl/codec_ctl_pkg.sv ----
/*
 * constants shared by both ends of the codec control link: word layout,
 * register indices, control register 1 fields, reset values, frame sizes.
 * assumes a 16-bit secondary word sent msb first on a sampled serial clock.
 */
package codec_ctl_pkg;
   // ***********************************************************
   // word layout
   // ***********************************************************
   localparam int WORD_BITS = 16;
   localparam int TOP_HI = 15;
   localparam int TOP_LO = 14;
   localparam int RW_BIT = 13;
   localparam int ADDR_HI = 12;
   localparam int ADDR_LO = 8;
   localparam int DATA_HI = 7;
   localparam int DATA_LO = 0;
   localparam logic [3:0] BIT_CNT_LAST = 4'hF;

   // ***********************************************************
   // register indices
   // ***********************************************************
   localparam logic [4:0] REG_NOP = 5'h00;
   localparam logic [4:0] REG_RESET_POWER_INPUT = 5'h01;
   localparam logic [4:0] REG_MODE_SECOND = 5'h02;
   localparam logic [4:0] REG_SLOT_DELAY = 5'h03;
   localparam logic [4:0] REG_GAIN_RATE = 5'h04;

   // ***********************************************************
   // control register 1 fields and reset values
   // ***********************************************************
   localparam int CR1_SOFT_RESET = 7;
   localparam int CR1_POWER_DOWN = 6;
   localparam int CR1_ADC_AUX = 5;
   localparam int CR1_MON_AUX = 4;
   localparam int CR1_MON_GAIN_HI = 3;
   localparam int CR1_MON_GAIN_LO = 2;
   localparam int CR1_LOOPBACK = 1;
   localparam int CR1_DAC16 = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // monitor gain codes
   localparam logic [1:0] MON_MUTE = 2'h0;
   localparam logic [1:0] MON_0DB = 2'h1;
   localparam logic [1:0] MON_M8DB = 2'h2;
   localparam logic [1:0] MON_M18DB = 2'h3;

   // link clock divider: half period in system clocks (host makes it)
   localparam logic [3:0] LINK_HALF_CYCLES = 4'h8;
endpackage

// ---- rtl/codec_ctl_if.sv ----
/*
 * link between host and codec control block: serial clock, frame,
 * data host to device, data device to host.
 * assumes both ends share the system clock for sampling.
 */
`timescale 1ns/1ps
`default_nettype none
interface codec_ctl_if;
   logic sclk;
   logic frame_sync;
   logic sdin;
   logic sdout;
   modport host (output sclk, output frame_sync, output sdin, input sdout);
   modport device (input sclk, input frame_sync, input sdin, output sdout);
endinterface
`default_nettype wire

// ---- rtl/codec_ctl_device.sv ----
/*
 * device end: shifts in 16-bit secondary words, keeps four control
 * registers, answers reads with the addressed byte in the next word out.
 * assumes link pins are asynchronous; they pass two flip-flops first.
 */
`timescale 1ns/1ps
`default_nettype none
module codec_ctl_device (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // link
   codec_ctl_if.device LINK,
   // control outputs
   output logic SOFT_RESET_OUT,
   output logic POWER_DOWN_OUT,
   output logic ADC_AUX_SEL_OUT,
   output logic MON_AUX_SEL_OUT,
   output logic [1:0] MON_GAIN_OUT,
   output logic LOOPBACK_OUT,
   output logic DAC16_MODE_OUT,
   output logic [7:0] MODE_SECOND_OUT,
   output logic [7:0] SLOT_DELAY_OUT,
   output logic [7:0] GAIN_RATE_OUT
);
   import codec_ctl_pkg::*;

   // ***********************************************************
   // synchronisers
   // ***********************************************************
   logic [2:0] pin_s;
   logic sclk_old_q, sclk_old_d;
   codec_ctl_pin_sync #(.WIDTH(3)) codec_ctl_pin_sync_i (
      .CLK_IN(CLK_IN),
      .NRST_IN(NRST_IN),
      .PIN_IN({LINK.sclk, LINK.frame_sync, LINK.sdin}),
      .SYNC_OUT(pin_s)
   );

   // edge detector resets to the idle level of sclk: no false edge
   always_comb begin
      sclk_old_d = pin_s[2];
   end

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         sclk_old_q <= 1'b0;
      end else begin
         sclk_old_q <= sclk_old_d;
      end
   end

   logic sclk_rise, sclk_fall, fs_s, din_s;
   assign sclk_rise = pin_s[2] & ~sclk_old_q;
   assign sclk_fall = ~pin_s[2] & sclk_old_q;
   assign fs_s = pin_s[1];
   assign din_s = pin_s[0];

   // ***********************************************************
   // shifter and registers
   // ***********************************************************
   logic [15:0] sh_q, sh_d, out_q, out_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] cr1_q, cr1_d, cr2_q, cr2_d, cr3_q, cr3_d, cr4_q, cr4_d;
   logic sr_q, sr_d, dout_q, dout_d;
   logic [15:0] w;
   logic [7:0] rd;

   always_comb begin
      sh_d = sh_q;
      out_d = out_q;
      cnt_d = cnt_q;
      cr1_d = cr1_q;
      cr2_d = cr2_q;
      cr3_d = cr3_q;
      cr4_d = cr4_q;
      dout_d = dout_q;
      sr_d = 1'b0;
      w = {sh_q[14:0], din_s};
      rd = 8'h00;
      // software reset bit clears itself after one cycle
      cr1_d[CR1_SOFT_RESET] = 1'b0;
      if (!fs_s) begin
         cnt_d = 4'h0;
      end else if (sclk_rise) begin
         sh_d = w;
         cnt_d = cnt_q + 4'h1;
         if (cnt_q == BIT_CNT_LAST) begin
            if (w[TOP_HI:TOP_LO] == 2'h0) begin
               case (w[ADDR_HI:ADDR_LO])
                  REG_RESET_POWER_INPUT: rd = cr1_q;
                  REG_MODE_SECOND: rd = cr2_q;
                  REG_SLOT_DELAY: rd = cr3_q;
                  REG_GAIN_RATE: rd = cr4_q;
                  default: rd = 8'h00;
               endcase
               if (!w[RW_BIT]) begin
                  case (w[ADDR_HI:ADDR_LO])
                     REG_RESET_POWER_INPUT: begin
                        cr1_d = w[DATA_HI:DATA_LO];
                        cr1_d[CR1_SOFT_RESET] = 1'b0;
                        sr_d = w[CR1_SOFT_RESET];
                     end
                     REG_MODE_SECOND: cr2_d = w[DATA_HI:DATA_LO];
                     REG_SLOT_DELAY: cr3_d = w[DATA_HI:DATA_LO];
                     REG_GAIN_RATE: cr4_d = w[DATA_HI:DATA_LO];
                     default: cr1_d = cr1_q;
                  endcase
                  out_d = WORD_RESET;
               end else begin
                  // read answers in next frame, register untouched
                  out_d = {w[15:8], rd};
               end
            end
         end
      end else if (sclk_fall) begin
         dout_d = out_q[4'hF - cnt_q];
      end
      if (sr_q) begin
         // software reset restores every control register
         cr1_d = CTRL_RESET;
         cr2_d = CTRL_RESET;
         cr3_d = CTRL_RESET;
         cr4_d = CTRL_RESET;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         sh_q <= WORD_RESET;
         out_q <= WORD_RESET;
         cnt_q <= 4'h0;
         cr1_q <= CTRL_RESET;
         cr2_q <= CTRL_RESET;
         cr3_q <= CTRL_RESET;
         cr4_q <= CTRL_RESET;
         sr_q <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         out_q <= out_d;
         cnt_q <= cnt_d;
         cr1_q <= cr1_d;
         cr2_q <= cr2_d;
         cr3_q <= cr3_d;
         cr4_q <= cr4_d;
         sr_q <= sr_d;
         dout_q <= dout_d;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign LINK.sdout = dout_q;
   assign SOFT_RESET_OUT = sr_q;
   assign POWER_DOWN_OUT = cr1_q[CR1_POWER_DOWN];
   assign ADC_AUX_SEL_OUT = cr1_q[CR1_ADC_AUX];
   assign MON_AUX_SEL_OUT = cr1_q[CR1_MON_AUX];
   assign MON_GAIN_OUT = cr1_q[CR1_MON_GAIN_HI:CR1_MON_GAIN_LO];
   assign LOOPBACK_OUT = cr1_q[CR1_LOOPBACK];
   assign DAC16_MODE_OUT = cr1_q[CR1_DAC16];
   assign MODE_SECOND_OUT = cr2_q;
   assign SLOT_DELAY_OUT = cr3_q;
   assign GAIN_RATE_OUT = cr4_q;
endmodule

// ***********************************************************
// two-stage synchroniser for the link pins
// ***********************************************************
// the first stage may go metastable, so nothing outside reads it;
// costs two cycles of latency, well inside the half period of sclk
module codec_ctl_pin_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // raw pins in, settled copies out
   input wire logic [WIDTH-1:0] PIN_IN,
   output logic [WIDTH-1:0] SYNC_OUT
);
   logic [WIDTH-1:0] meta_q, meta_d, sync_q, sync_d;

   always_comb begin
      meta_d = PIN_IN;
      sync_d = meta_q;
   end

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign SYNC_OUT = sync_q;
endmodule
`default_nettype wire

// ---- rtl/codec_ctl_host.sv ----
/*
 * host end: takes one 16-bit word from software, shifts it out on a
 * divided serial clock within a frame, returns the word shifted back.
 * assumes the device answers msb first, changing data on falling sclk.
 */
`timescale 1ns/1ps
`default_nettype none
module codec_ctl_host (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // software port
   input wire logic [1:0] ADDR_IN,
   input wire logic [15:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [15:0] RDATA_OUT,
   // link
   codec_ctl_if.host LINK
);
   import codec_ctl_pkg::*;

   typedef enum logic [1:0] {IDLE = 2'h0, SHIFT = 2'h1, DONE = 2'h3}
      state_e;
   state_e st_q, st_d;
   logic [15:0] tx_q, tx_d, rx_q, rx_d, rdata_q, rdata_d;
   logic [3:0] div_q, div_d, cnt_q, cnt_d;
   logic sclk_q, sclk_d, fs_q, fs_d, din_q, din_d;
   logic [1:0] sd_s;

   // sdout is synchronous to us in the bench; two flops before use
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) sd_s <= 2'h0;
      else sd_s <= {sd_s[0], LINK.sdout};
   end

   always_comb begin
      st_d = st_q;
      tx_d = tx_q;
      rx_d = rx_q;
      div_d = div_q;
      cnt_d = cnt_q;
      sclk_d = sclk_q;
      fs_d = fs_q;
      din_d = din_q;
      rdata_d = 16'h0000;
      case (st_q)
         IDLE: begin
            if (WR_IN && ADDR_IN == 2'h0) begin
               // top bits forced to zero
               tx_d = {2'h0, WDATA_IN[13:0]};
               din_d = 1'b0;
               fs_d = 1'b1;
               div_d = 4'h0;
               cnt_d = 4'h0;
               st_d = SHIFT;
            end
         end
         SHIFT: begin
            div_d = div_q + 4'h1;
            if (div_q == LINK_HALF_CYCLES - 4'h1) begin
               div_d = 4'h0;
               sclk_d = ~sclk_q;
               if (!sclk_q) begin
                  rx_d = {rx_q[14:0], sd_s[1]};
               end else begin
                  tx_d = {tx_q[14:0], 1'b0};
                  din_d = tx_q[14];
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == BIT_CNT_LAST) st_d = DONE;
               end
            end
         end
         DONE: begin
            fs_d = 1'b0;
            st_d = IDLE;
         end
         default: st_d = IDLE;
      endcase
      // set din with msb before first rising edge
      if (st_q == IDLE && st_d == SHIFT) din_d = 1'b0;
      if (st_q == SHIFT && cnt_q == 4'h0 && div_q == 4'h0 && !sclk_q)
         din_d = tx_q[15];
      if (RD_IN) begin
         case (ADDR_IN)
            2'h0: rdata_d = rx_q;
            2'h1: rdata_d = {15'h0000, st_q != IDLE};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         st_q <= IDLE;
         tx_q <= WORD_RESET;
         rx_q <= WORD_RESET;
         rdata_q <= WORD_RESET;
         div_q <= 4'h0;
         cnt_q <= 4'h0;
         sclk_q <= 1'b0;
         fs_q <= 1'b0;
         din_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         rdata_q <= rdata_d;
         div_q <= div_d;
         cnt_q <= cnt_d;
         sclk_q <= sclk_d;
         fs_q <= fs_d;
         din_q <= din_d;
      end
   end

   assign RDATA_OUT = rdata_q;
   assign LINK.sclk = sclk_q;
   assign LINK.frame_sync = fs_q;
   assign LINK.sdin = din_q;
endmodule
`default_nettype wire

// ---- dv/codec_ctl_properties.sv ----
/* link checker: framing, bit order and read answers on the host-device
   link. assumes link signals move on the system clock edge. */
`timescale 1ns/1ps
`default_nettype none
module codec_ctl_properties (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // link
   input wire logic sclk,
   input wire logic frame_sync,
   input wire logic sdin,
   input wire logic sdout
);
   // ****************
   // helper state
   // ****************
   logic sclk_last_q, fs_last_q, seen_q, rise, word_end;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] rx_q, rx_d, tx_q, tx_d, last_q, last_d;
   logic [7:0] cr1_q, cr1_d;
   assign rise = sclk && !sclk_last_q;
   assign word_end = fs_last_q && !frame_sync;
   always_comb begin
      cnt_d = frame_sync ? cnt_q + 5'(rise) : 5'h00;
      rx_d = (rise && frame_sync) ? {rx_q[14:0], sdin} : rx_q;
      tx_d = (rise && frame_sync) ? {tx_q[14:0], sdout} : tx_q;
      last_d = word_end ? rx_q : last_q;
      cr1_d = cr1_q;
      // shadow of control 1; bit 7 never sticks
      if (word_end && rx_q[15:8] == 8'h01) begin
         cr1_d = rx_q[7] ? 8'h00 : {1'b0, rx_q[6:0]};
      end
   end
   always_ff @(posedge CLK_IN) begin
      sclk_last_q <= NRST_IN && sclk;
      fs_last_q <= NRST_IN && frame_sync;
      seen_q <= NRST_IN && (seen_q || word_end);
      cnt_q <= NRST_IN ? cnt_d : 5'h00;
      rx_q <= NRST_IN ? rx_d : 16'h0000;
      tx_q <= NRST_IN ? tx_d : 16'h0000;
      last_q <= NRST_IN ? last_d : 16'h0000;
      cr1_q <= NRST_IN ? cr1_d : 8'h00;
   end
   // ****************
   // properties
   // ****************
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   a_frame_bit_count: assert property (
      $fell(frame_sync) |-> cnt_q == 5'h10) else $error("bad bit count");
   a_frame_min_len: assert property (
      $rose(frame_sync) |-> frame_sync[*8]) else $error("short frame");
   a_sdin_settled: assert property (
      $rose(sclk) && frame_sync |-> $stable(sdin)) else $error("sdin moved");
   a_top_bits_zero: assert property (
      $rose(sclk) && frame_sync && cnt_q < 5'h02 |-> !sdin)
      else $error("top bit set");
   a_sdout_settled: assert property (
      $rose(sclk) && frame_sync |-> $stable(sdout)) else $error("sdout moved");
   a_write_answer_zero: assert property (
      word_end && seen_q && !last_q[13] |-> tx_q == 16'h0000)
      else $error("write answer not zero");
   a_read_echo_head: assert property (
      word_end && seen_q && last_q[13] |-> tx_q[15:8] == last_q[15:8])
      else $error("read answer head wrong");
   a_cr1_readback: assert property (
      word_end && seen_q && last_q[15:8] == 8'h21 |-> tx_q[7:0] == cr1_q)
      else $error("control 1 readback wrong");
   c_read_frame: cover property (word_end && rx_q[13]);
   c_soft_reset: cover property (word_end && rx_q[15:7] == 9'h003);
   c_gain_top: cover property (word_end && rx_q[15:8] == 8'h01 && rx_q[3]);
endmodule
`default_nettype wire

// ---- dv/codec_control_register_bank_test.sv ----
/* bench for the host and device ends joined by the link interface.
   assumes a 100 MHz clock and the host's word/status software map. */
`timescale 1ns/1ps
`default_nettype none
module codec_control_register_bank_test;
   import codec_ctl_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata, exp_rx, w;
   logic soft_rst, pwr_dn, adc_aux, mon_aux, loopback, dac16;
   logic [1:0] mon_gain;
   logic [7:0] mode2, slot3, gain4;
   logic [7:0] regs [0:4];
   logic [15:0] corner [0:16] = '{16'h017F, 16'h2100, 16'h01C5, 16'h2100,
      16'h0100, 16'h0104, 16'h0108, 16'h010C, 16'h02FF, 16'h03A5, 16'h045A,
      16'h2200, 16'h2300, 16'h2400, 16'h0580, 16'hC155, 16'h2100};
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int sr_cnt = 0;
   int sr_exp = 0;
   always #5 clk = ~clk;
   codec_ctl_if codec_ctl_if_i ();
   codec_ctl_host codec_ctl_host_i (.CLK_IN(clk), .NRST_IN(nrst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .LINK(codec_ctl_if_i));
   codec_ctl_device codec_ctl_device_i (.CLK_IN(clk), .NRST_IN(nrst),
      .LINK(codec_ctl_if_i), .SOFT_RESET_OUT(soft_rst),
      .POWER_DOWN_OUT(pwr_dn), .ADC_AUX_SEL_OUT(adc_aux),
      .MON_AUX_SEL_OUT(mon_aux), .MON_GAIN_OUT(mon_gain),
      .LOOPBACK_OUT(loopback), .DAC16_MODE_OUT(dac16),
      .MODE_SECOND_OUT(mode2), .SLOT_DELAY_OUT(slot3), .GAIN_RATE_OUT(gain4));
   codec_ctl_properties codec_ctl_properties_i (.CLK_IN(clk), .NRST_IN(nrst),
      .sclk(codec_ctl_if_i.sclk), .frame_sync(codec_ctl_if_i.frame_sync),
      .sdin(codec_ctl_if_i.sdin), .sdout(codec_ctl_if_i.sdout));
   // ****************
   // tasks
   // ****************
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_sw(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_sw(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic [7:0] reg_val(input logic [4:0] a);
      return (a <= 5'h04) ? regs[a] : 8'h00;
   endfunction
   task automatic check_outs();
      chk({9'h000, pwr_dn, adc_aux, mon_aux, mon_gain, loopback, dac16},
         {9'h000, regs[1][6:0]}, "control 1");
      chk({mode2, slot3}, {regs[2], regs[3]}, "control 2 3");
      chk({8'h00, gain4}, {8'h00, regs[4]}, "control 4");
      chk(16'(sr_cnt), 16'(sr_exp), "reset pulses");
   endtask
   task automatic send(input logic [15:0] v);
      logic [15:0] s;
      logic [15:0] q;
      int n;
      q = {2'b00, v[13:0]};
      s = 16'h0001;
      n = 0;
      wr_sw(2'h0, v);
      // host is busy now, so this one must be dropped
      wr_sw(2'h0, ~v);
      while (s[0] !== 1'b0 && n < 1000) begin
         rd_sw(2'h1, s);
         n++;
      end
      if (n >= 1000) begin
         error_cnt++;
         $display("Error at %0t: host stayed busy", $time);
      end
      rd_sw(2'h0, s);
      chk(s, exp_rx, "answer word");
      exp_rx = q[13] ? {q[15:8], reg_val(q[12:8])} : 16'h0000;
      if (!q[13] && q[12:8] == 5'h01 && q[7]) begin
         regs = '{default: 8'h00};
         sr_exp++;
      end else if (!q[13] && q[12:8] == 5'h01) begin
         regs[1] = {1'b0, q[6:0]};
      end else if (!q[13] && q[12:8] inside {[5'h02:5'h04]}) begin
         regs[q[12:8]] = q[7:0];
      end
      check_outs();
   endtask
   // ****************
   // run
   // ****************
   always @(posedge clk) begin
      cyc++;
      if (soft_rst === 1'b1) sr_cnt++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("Error at %0t: run timed out", $time);
         wrap_up();
      end
   end
   initial begin
      void'($urandom(65));
      regs = '{default: 8'h00};
      exp_rx = 16'h0000;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      check_outs();
      foreach (corner[i]) send(corner[i]);
      repeat (30) begin
         w = 16'($urandom);
         if (w[13]) w[12:8] = 5'($urandom_range(0, 4));
         send(w);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
